// >>> src/mad_defines.vh
/*
  Constants for the move/arithmetic datapath: operation codes, sizes,
  register-view selectors and flag positions.
  Assumes it is included once per compilation unit by its bare name.
*/
`ifndef MAD_DEFINES_VH
`define MAD_DEFINES_VH

// ==========================================
// operation codes
`define MAD_OP_W 5
`define MAD_OP_NOP 5'h00
`define MAD_OP_MOVE_RR 5'h01
`define MAD_OP_MOVE_IMM 5'h02
`define MAD_OP_LOAD 5'h03
`define MAD_OP_STORE 5'h04
`define MAD_OP_POP 5'h05
`define MAD_OP_PUSH 5'h06
`define MAD_OP_ADD 5'h07
`define MAD_OP_SUB 5'h08
`define MAD_OP_ADDC 5'h09
`define MAD_OP_SUBC 5'h0A
`define MAD_OP_STEP_UP 5'h0B
`define MAD_OP_STEP_DOWN 5'h0C
`define MAD_OP_PTR_ADJ 5'h0D
`define MAD_OP_PTR_SHR 5'h0E
`define MAD_OP_BCD_SUM 5'h0F
`define MAD_OP_BCD_DIFF 5'h10
`define MAD_OP_MULU 5'h11
`define MAD_OP_MULS 5'h12
`define MAD_OP_PLOAD 5'h13
`define MAD_OP_PSTORE 5'h14

// ==========================================
// operand sizes
`define MAD_SZ_B 2'h0
`define MAD_SZ_W 2'h1
`define MAD_SZ_L 2'h2

// ==========================================
// register view: sel[3] picks upper half (E or H), sel[2:0] register number
`define MAD_SP_INDEX 3'h7
`define MAD_SEL_HI 3

// ==========================================
// flag positions in flag_register image (H N Z V C in low bits)
`define MAD_FLAG_C 0
`define MAD_FLAG_V 1
`define MAD_FLAG_Z 2
`define MAD_FLAG_N 3
`define MAD_FLAG_H 5

// ==========================================
// step, stack and decimal adjust constants
`define MAD_STEP_1 32'h00000001
`define MAD_STEP_2 32'h00000002
`define MAD_STEP_4 32'h00000004
`define MAD_BCD_6 8'h06
`define MAD_BCD_60 8'h60
`define MAD_BCD_9 4'h9

`endif

// >>> src/mad_datapath.v
/*
  Move/arithmetic execution datapath with an eight-entry 32-bit general
  register file seen as byte, word or longword registers.
  Assumes a sequencer that issues one operation at a time on op_valid_in
  and a memory that answers every request with mem_ack_in.
*/
// How it works
// - registers read as 8-, 16- or 32-bit views of one shared store
// - transfer_data copies B/W/L register, memory, or immediate into place
// - peripheral_load_sync and peripheral_store_sync are rejected as unsupported
// - pop loads from stack pointer address, then increments the pointer unless the pointer is the target
// - push decrements the stack pointer first, then stores there
// - add and subtract B/W/L, target with register or immediate
// - subtract of an immediate byte is refused
// - sum_with_carry and difference_with_borrow are byte-only, use carry
// - step_up and step_down change a register by 1 or 2
// - byte-sized steps allow only 1
// - pointer_adjust and pointer_shrink add/subtract 1, 2 or 4 on 32-bit
// - decimal adjust fixes a byte sum or difference to BCD using flags
// - unsigned_product: 8x8 to 16 or 16x16 to 32 bits
// - signed_product: two's complement 8x8 to 16 or 16x16 to 32
`default_nettype none
`include "mad_defines.vh"

module mad_datapath #(
  parameter ADDR_W = 24
) (
  input wire clk_in,
  input wire reset_in,
  input wire op_valid_in,
  input wire [4:0] op_code_in,
  input wire [1:0] op_size_in,
  input wire [3:0] target_sel_in,
  input wire [3:0] source_sel_in,
  input wire [31:0] imm_in,
  input wire use_imm_in,
  input wire [ADDR_W-1:0] mem_addr_in,
  input wire [7:0] flags_in,
  input wire [31:0] mem_rdata_in,
  input wire mem_ack_in,
  output wire op_ready_out,
  output reg op_done_out,
  output reg op_illegal_out,
  output reg [7:0] flags_out,
  output reg mem_req_out,
  output reg mem_write_out,
  output reg [1:0] mem_size_out,
  output reg [ADDR_W-1:0] mem_addr_out,
  output reg [31:0] mem_wdata_out,
  output reg [31:0] sp_out
);

  localparam ST_IDLE = 2'b01;
  localparam ST_MEM = 2'b10;

  reg [31:0] regs [0:7];
  reg [1:0] state;
  reg [1:0] mem_size_q;
  reg [3:0] mem_target;
  reg mem_is_pop;

  // ==========================================
  // register views
  function [31:0] read_view;
    input [3:0] sel;
    input [1:0] size;
    input [31:0] word;
    begin
      if (size == `MAD_SZ_L) begin
        read_view = word;
      end else if (size == `MAD_SZ_W) begin
        read_view = sel[`MAD_SEL_HI] ? {16'h0000, word[31:16]} : {16'h0000, word[15:0]};
      end else begin
        read_view = sel[`MAD_SEL_HI] ? {24'h000000, word[15:8]} : {24'h000000, word[7:0]};
      end
    end
  endfunction

  function [31:0] write_view;
    input [3:0] sel;
    input [1:0] size;
    input [31:0] word;
    input [31:0] val;
    begin
      if (size == `MAD_SZ_L) begin
        write_view = val;
      end else if (size == `MAD_SZ_W) begin
        write_view = sel[`MAD_SEL_HI] ? {val[15:0], word[15:0]} : {word[31:16], val[15:0]};
      end else begin
        write_view = sel[`MAD_SEL_HI] ? {word[31:16], val[7:0], word[7:0]}
                                      : {word[31:8], val[7:0]};
      end
    end
  endfunction

  function sign_bit;
    input [1:0] size;
    input [31:0] v;
    begin
      if (size == `MAD_SZ_L) begin
        sign_bit = v[31];
      end else if (size == `MAD_SZ_W) begin
        sign_bit = v[15];
      end else begin
        sign_bit = v[7];
      end
    end
  endfunction

  function [31:0] trim;
    input [1:0] size;
    input [31:0] v;
    begin
      if (size == `MAD_SZ_L) begin
        trim = v;
      end else if (size == `MAD_SZ_W) begin
        trim = {16'h0000, v[15:0]};
      end else begin
        trim = {24'h000000, v[7:0]};
      end
    end
  endfunction

  wire [31:0] tgt_word = regs[target_sel_in[2:0]];
  wire [31:0] src_word = regs[source_sel_in[2:0]];
  wire [31:0] a = read_view(target_sel_in, op_size_in, tgt_word);
  wire [31:0] b = use_imm_in ? trim(op_size_in, imm_in)
                             : read_view(source_sel_in, op_size_in, src_word);
  wire [31:0] sp = regs[`MAD_SP_INDEX];
  wire [31:0] stack_step = (op_size_in == `MAD_SZ_L) ? `MAD_STEP_4 : `MAD_STEP_2;
  wire carry_in = flags_in[`MAD_FLAG_C];
  // products are sized by their targets, so no high bits are lost to self-sizing
  wire [15:0] mulu_b = a[7:0] * b[7:0];
  wire [31:0] mulu_w = a[15:0] * b[15:0];
  wire signed [15:0] muls_b = $signed(a[7:0]) * $signed(b[7:0]);
  wire signed [31:0] muls_w = $signed(a[15:0]) * $signed(b[15:0]);

  // ==========================================
  // combinational result
  reg [32:0] res;
  reg [31:0] res_val;
  reg writes;
  reg illegal;
  reg set_flags;
  reg sub_op;
  reg [7:0] bcd;
  reg bcd_c;
  reg [31:0] prod;

  always @* begin
    res = 33'h0;
    writes = 1'b0;
    illegal = 1'b0;
    set_flags = 1'b0;
    sub_op = 1'b0;
    bcd = a[7:0];
    bcd_c = carry_in;
    prod = 32'h0;
    case (op_code_in)
      `MAD_OP_MOVE_RR, `MAD_OP_MOVE_IMM: begin
        res = {1'b0, b};
        writes = 1'b1;
      end
      `MAD_OP_ADD: begin
        res = {1'b0, a} + {1'b0, b};
        writes = 1'b1;
        set_flags = 1'b1;
      end
      `MAD_OP_SUB: begin
        illegal = use_imm_in && (op_size_in == `MAD_SZ_B);
        res = {1'b0, a} - {1'b0, b};
        writes = !illegal;
        set_flags = !illegal;
        sub_op = 1'b1;
      end
      `MAD_OP_ADDC, `MAD_OP_SUBC: begin
        illegal = (op_size_in != `MAD_SZ_B);
        sub_op = (op_code_in == `MAD_OP_SUBC);
        res = sub_op ? {25'h0, a[7:0]} - {25'h0, b[7:0]} - {32'h0, carry_in}
                     : {25'h0, a[7:0]} + {25'h0, b[7:0]} + {32'h0, carry_in};
        writes = !illegal;
        set_flags = !illegal;
      end
      `MAD_OP_STEP_UP, `MAD_OP_STEP_DOWN: begin
        illegal = (imm_in[1:0] != 2'h1 && imm_in[1:0] != 2'h2) ||
                  (op_size_in == `MAD_SZ_B && imm_in[1:0] != 2'h1);
        sub_op = (op_code_in == `MAD_OP_STEP_DOWN);
        res = sub_op ? {1'b0, a} - {31'h0, imm_in[1:0]}
                     : {1'b0, a} + {31'h0, imm_in[1:0]};
        writes = !illegal;
        set_flags = !illegal;
      end
      `MAD_OP_PTR_ADJ, `MAD_OP_PTR_SHR: begin
        illegal = (op_size_in != `MAD_SZ_L) ||
                  (imm_in[2:0] != 3'h1 && imm_in[2:0] != 3'h2 && imm_in[2:0] != 3'h4);
        res = (op_code_in == `MAD_OP_PTR_SHR) ? {1'b0, a} - {30'h0, imm_in[2:0]}
                                               : {1'b0, a} + {30'h0, imm_in[2:0]};
        writes = !illegal;
      end
      `MAD_OP_BCD_SUM: begin
        if (flags_in[`MAD_FLAG_H] || a[3:0] > `MAD_BCD_9) begin
          bcd = bcd + `MAD_BCD_6;
        end
        if (carry_in || a[7:0] > 8'h99) begin
          bcd = bcd + `MAD_BCD_60;
          bcd_c = 1'b1;
        end
        res = {25'h0, bcd};
        illegal = (op_size_in != `MAD_SZ_B);
        writes = !illegal;
        set_flags = !illegal;
      end
      `MAD_OP_BCD_DIFF: begin
        if (flags_in[`MAD_FLAG_H]) begin
          bcd = bcd - `MAD_BCD_6;
        end
        if (carry_in) begin
          bcd = bcd - `MAD_BCD_60;
        end
        res = {25'h0, bcd};
        illegal = (op_size_in != `MAD_SZ_B);
        writes = !illegal;
        set_flags = !illegal;
      end
      `MAD_OP_MULU: begin
        prod = (op_size_in == `MAD_SZ_B) ? {16'h0000, mulu_b} : mulu_w;
        illegal = (op_size_in == `MAD_SZ_L) || use_imm_in;
        res = {1'b0, prod};
        writes = !illegal;
      end
      `MAD_OP_MULS: begin
        if (op_size_in == `MAD_SZ_B) begin
          prod = {16'h0000, muls_b};
        end else begin
          prod = muls_w;
        end
        illegal = (op_size_in == `MAD_SZ_L) || use_imm_in;
        res = {1'b0, prod};
        writes = !illegal;
      end
      `MAD_OP_PLOAD, `MAD_OP_PSTORE: begin
        illegal = 1'b1;
      end
      `MAD_OP_LOAD, `MAD_OP_STORE, `MAD_OP_NOP: begin
        res = 33'h0;
      end
      `MAD_OP_POP, `MAD_OP_PUSH: begin
        illegal = (op_size_in == `MAD_SZ_B);
      end
      default: begin
        illegal = 1'b1;
      end
    endcase
    res_val = res[31:0];
  end

  // product sizes widen the write: B gives a word, W gives a longword
  wire [1:0] wr_size = (op_code_in == `MAD_OP_MULU || op_code_in == `MAD_OP_MULS) ?
                       ((op_size_in == `MAD_SZ_B) ? `MAD_SZ_W : `MAD_SZ_L) : op_size_in;
  wire [31:0] res_trim = trim(op_size_in, res_val);
  wire res_carry = (op_size_in == `MAD_SZ_L) ? res[32] :
                   (op_size_in == `MAD_SZ_W) ? res_val[16] : res_val[8];
  wire a_s = sign_bit(op_size_in, a);
  wire b_s = sign_bit(op_size_in, b) ^ sub_op;
  wire r_s = sign_bit(op_size_in, res_val);

  assign op_ready_out = (state == ST_IDLE);

  // ==========================================
  // sequencing
  integer i;
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (i = 0; i < 8; i = i + 1) begin
        regs[i] <= 32'h00000000;
      end
      state <= ST_IDLE;
      op_done_out <= 1'b0;
      op_illegal_out <= 1'b0;
      flags_out <= 8'h00;
      mem_req_out <= 1'b0;
      mem_write_out <= 1'b0;
      mem_size_out <= `MAD_SZ_B;
      mem_addr_out <= {ADDR_W{1'b0}};
      mem_wdata_out <= 32'h00000000;
      sp_out <= 32'h00000000;
      mem_size_q <= `MAD_SZ_B;
      mem_target <= 4'h0;
      mem_is_pop <= 1'b0;
    end else begin
      op_done_out <= 1'b0;
      op_illegal_out <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (op_valid_in) begin
            if (illegal) begin
              op_illegal_out <= 1'b1;
              op_done_out <= 1'b1;
            end else if (op_code_in == `MAD_OP_LOAD || op_code_in == `MAD_OP_POP) begin
              mem_req_out <= 1'b1;
              mem_write_out <= 1'b0;
              mem_size_out <= op_size_in;
              mem_addr_out <= (op_code_in == `MAD_OP_POP) ? sp[ADDR_W-1:0] : mem_addr_in;
              mem_size_q <= op_size_in;
              mem_target <= target_sel_in;
              mem_is_pop <= (op_code_in == `MAD_OP_POP);
              state <= ST_MEM;
            end else if (op_code_in == `MAD_OP_STORE || op_code_in == `MAD_OP_PUSH) begin
              mem_req_out <= 1'b1;
              mem_write_out <= 1'b1;
              mem_size_out <= op_size_in;
              mem_wdata_out <= read_view(source_sel_in, op_size_in, src_word);
              mem_is_pop <= 1'b0;
              if (op_code_in == `MAD_OP_PUSH) begin
                regs[`MAD_SP_INDEX] <= sp - stack_step;
                mem_addr_out <= sp[ADDR_W-1:0] - stack_step[ADDR_W-1:0];
              end else begin
                mem_addr_out <= mem_addr_in;
              end
              state <= ST_MEM;
            end else begin
              if (writes) begin
                regs[target_sel_in[2:0]] <= write_view(target_sel_in, wr_size, tgt_word,
                                                       res_val);
              end
              if (set_flags) begin
                flags_out <= flags_in;
                flags_out[`MAD_FLAG_N] <= sign_bit(op_size_in, res_trim);
                flags_out[`MAD_FLAG_Z] <= (res_trim == 32'h0);
                flags_out[`MAD_FLAG_V] <= (a_s == b_s) && (r_s != a_s);
                if (op_code_in == `MAD_OP_BCD_SUM || op_code_in == `MAD_OP_BCD_DIFF) begin
                  flags_out[`MAD_FLAG_C] <= bcd_c;
                end else if (op_code_in != `MAD_OP_STEP_UP &&
                             op_code_in != `MAD_OP_STEP_DOWN) begin
                  flags_out[`MAD_FLAG_C] <= res_carry;
                end
              end
              op_done_out <= 1'b1;
            end
          end
        end
        ST_MEM: begin
          if (mem_ack_in) begin
            mem_req_out <= 1'b0;
            if (!mem_write_out) begin
              regs[mem_target[2:0]] <= write_view(mem_target, mem_size_q,
                                                  regs[mem_target[2:0]], mem_rdata_in);
              if (mem_is_pop) begin
                // pointer bumps after the load; pop into the pointer itself keeps the data
                if (mem_target[2:0] != `MAD_SP_INDEX) begin
                  regs[`MAD_SP_INDEX] <= sp + ((mem_size_q == `MAD_SZ_L) ? `MAD_STEP_4
                                                                       : `MAD_STEP_2);
                end
              end
            end
            op_done_out <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
      sp_out <= regs[`MAD_SP_INDEX];
    end
  end

endmodule // mad_datapath
`default_nettype wire

// >>> testbench/mad_datapath_monitor.sv
/*
  Checker for the move/arithmetic datapath, bound to its top ports.
  Assumes mad_defines.vh is on the include path.
*/
`default_nettype none
`include "mad_defines.vh"
module mad_datapath_monitor #(
  parameter int ADDR_W = 24
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic op_valid_in,
  input wire logic [4:0] op_code_in,
  input wire logic [1:0] op_size_in,
  input wire logic [31:0] imm_in,
  input wire logic use_imm_in,
  input wire logic mem_ack_in,
  input wire logic op_ready_out,
  input wire logic op_done_out,
  input wire logic op_illegal_out,
  input wire logic mem_req_out,
  input wire logic mem_write_out,
  input wire logic [1:0] mem_size_out,
  input wire logic [ADDR_W-1:0] mem_addr_out,
  input wire logic [31:0] mem_wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  logic take;
  logic [4:0] c;
  assign take = op_valid_in && op_ready_out;
  assign c = op_code_in;
  // ==========================================
  // refusals
  property p_periph;
    take && (c == `MAD_OP_PLOAD || c == `MAD_OP_PSTORE) |-> ##[1:2] op_done_out && op_illegal_out;
  endproperty
  a_periph: assert property (p_periph) else $error("peripheral op accepted");
  property p_subimm;
    take && c == `MAD_OP_SUB && op_size_in == `MAD_SZ_B && use_imm_in |=> op_illegal_out;
  endproperty
  a_subimm: assert property (p_subimm) else $error("byte sub immediate accepted");
  property p_carry;
    take && (c == `MAD_OP_ADDC || c == `MAD_OP_SUBC) && op_size_in != `MAD_SZ_B |=> op_illegal_out;
  endproperty
  a_carry: assert property (p_carry) else $error("wide carry op accepted");
  property p_step;
    take && (c == `MAD_OP_STEP_UP || c == `MAD_OP_STEP_DOWN) && op_size_in == `MAD_SZ_B
      && imm_in == 32'h2 |=> op_done_out && op_illegal_out;
  endproperty
  a_step: assert property (p_step) else $error("byte step of two accepted");
  property p_ptr;
    take && (c == `MAD_OP_PTR_ADJ || c == `MAD_OP_PTR_SHR) && op_size_in != `MAD_SZ_L
      |=> op_illegal_out;
  endproperty
  a_ptr: assert property (p_ptr) else $error("narrow pointer op accepted");
  property p_mul;
    take && (c == `MAD_OP_MULU || c == `MAD_OP_MULS) && op_size_in == `MAD_SZ_L |=> op_illegal_out;
  endproperty
  a_mul: assert property (p_mul) else $error("long multiply accepted");
  // ==========================================
  // normal flow
  property p_add;
    take && c == `MAD_OP_ADD |=> op_done_out && !op_illegal_out && !mem_req_out;
  endproperty
  a_add: assert property (p_add) else $error("add not done in one cycle");
  property p_push;
    take && c == `MAD_OP_PUSH && op_size_in != `MAD_SZ_B
      |=> mem_req_out && mem_write_out && mem_size_out == $past(op_size_in);
  endproperty
  a_push: assert property (p_push) else $error("push did not write");
  property p_pop;
    take && c == `MAD_OP_POP && op_size_in != `MAD_SZ_B |=> mem_req_out && !mem_write_out;
  endproperty
  a_pop: assert property (p_pop) else $error("pop did not read");
  property p_hold;
    mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out) && $stable(mem_wdata_out);
  endproperty
  a_hold: assert property (p_hold) else $error("memory request dropped early");
  cover property (take && c == `MAD_OP_PUSH);
  cover property (op_illegal_out);
  cover property (mem_req_out && mem_ack_in && !mem_write_out);
endmodule // mad_datapath_monitor
bind mad_datapath mad_datapath_monitor #(.ADDR_W(ADDR_W)) mad_datapath_monitor_inst (
  .clk_in(clk_in), .reset_in(reset_in), .op_valid_in(op_valid_in), .op_code_in(op_code_in),
  .op_size_in(op_size_in), .imm_in(imm_in), .use_imm_in(use_imm_in), .mem_ack_in(mem_ack_in),
  .op_ready_out(op_ready_out), .op_done_out(op_done_out), .op_illegal_out(op_illegal_out),
  .mem_req_out(mem_req_out), .mem_write_out(mem_write_out), .mem_size_out(mem_size_out),
  .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out)
);
`default_nettype wire

// >>> testbench/mad_mem_model.sv
/*
  Memory and stack model answering the datapath's requests.
  Assumes the request stands until ack_out is seen; wait_in sets extra wait cycles.
*/
`default_nettype none
module mad_mem_model #(
  parameter int ADDR_W = 24
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic req_in,
  input wire logic write_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wait_in,
  output logic ack_out,
  output logic [31:0] rdata_out,
  output logic [31:0] last_wdata_out,
  output logic [ADDR_W-1:0] last_addr_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // only the low 12 address bits pick a word; enough for the bench's stack and data
  logic [31:0] mem [0:4095];
  logic [3:0] cnt;
  task automatic poke(input int a, input logic [31:0] d);
    mem[a[11:0]] = d;
  endtask
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      ack_out <= 1'b0;
      cnt <= 4'h0;
      rdata_out <= 32'h5A5A5A5A;
      last_wdata_out <= 32'h0;
      last_addr_out <= '0;
    end else begin
      ack_out <= 1'b0;
      // idle bus toggles so stale data never looks valid
      rdata_out <= ~rdata_out;
      if (req_in && !ack_out) begin
        if (cnt < wait_in) begin
          cnt <= cnt + 4'h1;
        end else begin
          cnt <= 4'h0;
          ack_out <= 1'b1;
          last_addr_out <= addr_in;
          if (write_in) begin
            mem[addr_in[11:0]] <= wdata_in;
            last_wdata_out <= wdata_in;
          end else begin
            rdata_out <= mem[addr_in[11:0]];
          end
        end
      end
    end
  end
endmodule // mad_mem_model
`default_nettype wire

// >>> testbench/mad_datapath_tb.sv
/*
  Self-checking bench for the move/arithmetic datapath.
  Assumes the monitor bind and the memory model are compiled alongside.
*/
`default_nettype none
`include "mad_defines.vh"
module mad_datapath_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0, reset_in = 1'b1, op_valid_in = 1'b0, use_imm_in = 1'b0, ill;
  logic [4:0] op_code_in = 5'h00;
  logic [1:0] op_size_in = 2'h0, mem_size_out;
  logic [3:0] target_sel_in = 4'h0, source_sel_in = 4'h0, mem_wait = 4'h0;
  logic [31:0] imm_in = 32'h0, mem_rdata_in, mem_wdata_out, sp_out, last_wdata;
  logic [23:0] mem_addr_in = 24'h0, mem_addr_out, last_addr;
  logic [7:0] flags_in = 8'h00, flags_out;
  logic mem_ack_in, op_ready_out, op_done_out, op_illegal_out, mem_req_out, mem_write_out;
  int error_cnt = 0, n_compared = 0;
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
  always #5 clk_in = ~clk_in;
  mad_datapath #(.ADDR_W(24)) mad_datapath_inst (
    .clk_in(clk_in), .reset_in(reset_in), .op_valid_in(op_valid_in), .op_code_in(op_code_in),
    .op_size_in(op_size_in), .target_sel_in(target_sel_in), .source_sel_in(source_sel_in),
    .imm_in(imm_in), .use_imm_in(use_imm_in), .mem_addr_in(mem_addr_in), .flags_in(flags_in),
    .mem_rdata_in(mem_rdata_in), .mem_ack_in(mem_ack_in), .op_ready_out(op_ready_out),
    .op_done_out(op_done_out), .op_illegal_out(op_illegal_out), .flags_out(flags_out),
    .mem_req_out(mem_req_out), .mem_write_out(mem_write_out), .mem_size_out(mem_size_out),
    .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out), .sp_out(sp_out));
  mad_mem_model #(.ADDR_W(24)) mad_mem_model_inst (
    .clk_in(clk_in), .reset_in(reset_in), .req_in(mem_req_out), .write_in(mem_write_out),
    .addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .wait_in(mem_wait),
    .ack_out(mem_ack_in), .rdata_out(mem_rdata_in), .last_wdata_out(last_wdata),
    .last_addr_out(last_addr));
  // ==========================================
  // shared tasks
  task automatic op(input logic [4:0] c, input logic [1:0] s, input logic [3:0] t,
                    input logic [3:0] r, input logic [31:0] i, input logic u,
                    input logic [23:0] a);
    int n;
    n = 0;
    @(posedge clk_in);
    #1;
    {op_code_in, op_size_in, target_sel_in, source_sel_in} = {c, s, t, r};
    {imm_in, use_imm_in, mem_addr_in, op_valid_in} = {i, u, a, 1'b1};
    while (op_ready_out !== 1'b1 && n < 100) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    @(posedge clk_in);
    #1;
    op_valid_in = 1'b0;
    n = 0;
    while (op_done_out !== 1'b1 && n < 200) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    ill = op_illegal_out;
    `CHK(op_done_out, 1'b1)
  endtask
  task automatic mv(input logic [3:0] t, input logic [1:0] s, input logic [31:0] v);
    op(`MAD_OP_MOVE_IMM, s, t, t, v, 1'b1, 24'h0);
    `CHK(ill, 1'b0)
  endtask
  task automatic rd(input logic [3:0] r, input logic [1:0] s, input logic [31:0] e);
    logic [31:0] m;
    m = s == `MAD_SZ_B ? 32'hFF : s == `MAD_SZ_W ? 32'hFFFF : 32'hFFFFFFFF;
    op(`MAD_OP_STORE, s, r, r, 32'h0, 1'b0, 24'h000200);
    `CHK(last_wdata & m, e)
  endtask
  task automatic refused(input logic [4:0] c, input logic [1:0] s, input logic [31:0] i,
                         input logic u);
    op(c, s, 4'h1, 4'h2, i, u, 24'h000300);
    `CHK(ill, 1'b1)
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_views_moves;
    mv(4'h1, `MAD_SZ_L, 32'h12345678);
    rd(4'h1, `MAD_SZ_W, 32'h5678);
    rd(4'h9, `MAD_SZ_W, 32'h1234);
    rd(4'h9, `MAD_SZ_B, 32'h56);
    mv(4'h9, `MAD_SZ_B, 32'hAB);
    rd(4'h1, `MAD_SZ_L, 32'h1234AB78);
    op(`MAD_OP_MOVE_RR, `MAD_SZ_L, 4'h2, 4'h1, 32'h0, 1'b0, 24'h0);
    rd(4'h2, `MAD_SZ_L, 32'h1234AB78);
    mad_mem_model_inst.poke(32'h300, 32'hCAFEF00D);
    op(`MAD_OP_LOAD, `MAD_SZ_L, 4'h3, 4'h3, 32'h0, 1'b0, 24'h000300);
    rd(4'h3, `MAD_SZ_L, 32'hCAFEF00D);
    refused(`MAD_OP_PLOAD, `MAD_SZ_B, 32'h0, 1'b0);
    refused(`MAD_OP_PSTORE, `MAD_SZ_B, 32'h0, 1'b0);
    $display("test views_moves done");
  endtask
  task automatic t_arith;
    op(`MAD_OP_ADD, `MAD_SZ_W, 4'h1, 4'h0, 32'h1, 1'b1, 24'h0);
    rd(4'h1, `MAD_SZ_W, 32'hAB79);
    op(`MAD_OP_SUB, `MAD_SZ_W, 4'h1, 4'h2, 32'h0, 1'b0, 24'h0);
    rd(4'h1, `MAD_SZ_L, 32'h12340001);
    op(`MAD_OP_ADD, `MAD_SZ_L, 4'h1, 4'h0, 32'hFFFFFFFF, 1'b1, 24'h0);
    `CHK(flags_out, 8'h01)
    rd(4'h1, `MAD_SZ_L, 32'h12340000);
    refused(`MAD_OP_SUB, `MAD_SZ_B, 32'h1, 1'b1);
    flags_in = 8'h01;
    mv(4'h3, `MAD_SZ_B, 32'h10);
    op(`MAD_OP_ADDC, `MAD_SZ_B, 4'h3, 4'h0, 32'h05, 1'b1, 24'h0);
    rd(4'h3, `MAD_SZ_B, 32'h16);
    op(`MAD_OP_SUBC, `MAD_SZ_B, 4'h3, 4'h0, 32'h06, 1'b1, 24'h0);
    rd(4'h3, `MAD_SZ_B, 32'h0F);
    refused(`MAD_OP_ADDC, `MAD_SZ_W, 32'h1, 1'b1);
    flags_in = 8'h00;
    $display("test arith done");
  endtask
  task automatic t_steps;
    refused(`MAD_OP_STEP_UP, `MAD_SZ_B, 32'h2, 1'b1);
    mv(4'h4, `MAD_SZ_W, 32'h0);
    op(`MAD_OP_STEP_DOWN, `MAD_SZ_W, 4'h4, 4'h0, 32'h2, 1'b1, 24'h0);
    rd(4'h4, `MAD_SZ_W, 32'hFFFE);
    op(`MAD_OP_STEP_UP, `MAD_SZ_B, 4'h4, 4'h0, 32'h1, 1'b1, 24'h0);
    `CHK(flags_out, 8'h08)
    rd(4'h4, `MAD_SZ_W, 32'hFFFF);
    mv(4'h5, `MAD_SZ_L, 32'hFFFFFFFE);
    op(`MAD_OP_PTR_ADJ, `MAD_SZ_L, 4'h5, 4'h0, 32'h4, 1'b1, 24'h0);
    rd(4'h5, `MAD_SZ_L, 32'h2);
    op(`MAD_OP_PTR_SHR, `MAD_SZ_L, 4'h5, 4'h0, 32'h1, 1'b1, 24'h0);
    rd(4'h5, `MAD_SZ_L, 32'h1);
    refused(`MAD_OP_PTR_ADJ, `MAD_SZ_W, 32'h1, 1'b1);
    mv(4'h3, `MAD_SZ_B, 32'h3C);
    op(`MAD_OP_BCD_SUM, `MAD_SZ_B, 4'h3, 4'h3, 32'h0, 1'b0, 24'h0);
    rd(4'h3, `MAD_SZ_B, 32'h42);
    flags_in = 8'h20;
    mv(4'h3, `MAD_SZ_B, 32'h4F);
    op(`MAD_OP_BCD_DIFF, `MAD_SZ_B, 4'h3, 4'h3, 32'h0, 1'b0, 24'h0);
    rd(4'h3, `MAD_SZ_B, 32'h49);
    flags_in = 8'h00;
    $display("test steps done");
  endtask
  task automatic t_mul;
    mv(4'h4, `MAD_SZ_B, 32'hFF);
    mv(4'h5, `MAD_SZ_B, 32'h02);
    op(`MAD_OP_MULU, `MAD_SZ_B, 4'h4, 4'h5, 32'h0, 1'b0, 24'h0);
    rd(4'h4, `MAD_SZ_W, 32'h01FE);
    mv(4'h4, `MAD_SZ_B, 32'hFF);
    op(`MAD_OP_MULS, `MAD_SZ_B, 4'h4, 4'h5, 32'h0, 1'b0, 24'h0);
    rd(4'h4, `MAD_SZ_W, 32'hFFFE);
    mv(4'h5, `MAD_SZ_W, 32'h3);
    op(`MAD_OP_MULS, `MAD_SZ_W, 4'h4, 4'h5, 32'h0, 1'b0, 24'h0);
    rd(4'h4, `MAD_SZ_L, 32'hFFFFFFFA);
    refused(`MAD_OP_MULU, `MAD_SZ_L, 32'h0, 1'b0);
    $display("test mul done");
  endtask
  task automatic t_stack;
    mem_wait = 4'h3;
    mv(4'h7, `MAD_SZ_L, 32'h1000);
    mv(4'h1, `MAD_SZ_L, 32'h89ABCDEF);
    op(`MAD_OP_PUSH, `MAD_SZ_L, 4'h1, 4'h1, 32'h0, 1'b0, 24'h0);
    `CHK(last_addr, 24'h000FFC)
    `CHK(last_wdata, 32'h89ABCDEF)
    op(`MAD_OP_PUSH, `MAD_SZ_W, 4'h1, 4'h1, 32'h0, 1'b0, 24'h0);
    @(posedge clk_in);
    #1;
    `CHK(sp_out, 32'h0FFA)
    op(`MAD_OP_POP, `MAD_SZ_W, 4'h6, 4'h6, 32'h0, 1'b0, 24'h0);
    `CHK(last_addr, 24'h000FFA)
    @(posedge clk_in);
    #1;
    `CHK(sp_out, 32'h0FFC)
    op(`MAD_OP_POP, `MAD_SZ_L, 4'h6, 4'h6, 32'h0, 1'b0, 24'h0);
    @(posedge clk_in);
    #1;
    `CHK(sp_out, 32'h1000)
    rd(4'h6, `MAD_SZ_L, 32'h89ABCDEF);
    refused(`MAD_OP_PUSH, `MAD_SZ_B, 32'h0, 1'b0);
    mem_wait = 4'h0;
    $display("test stack done");
  endtask
  initial begin
    #200us;
    error_cnt++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge clk_in);
    #1;
    reset_in = 1'b0;
    `CHK(op_ready_out, 1'b1)
    `CHK(sp_out, 32'h0)
    t_views_moves();
    t_arith();
    t_steps();
    t_mul();
    t_stack();
    final_report();
  end
endmodule // mad_datapath_tb
`default_nettype wire
